//--- src/rsb_pkg.sv
package rsb_pkg;
  // boot mode codes
  localparam logic [3:0] BOOT_HOST_NOPLL = 4'h0;
  localparam logic [3:0] BOOT_I2C = 4'h1;
  localparam logic [3:0] BOOT_HOST_P2M32 = 4'h2;
  localparam logic [3:0] BOOT_RSV_3 = 4'h3;
  localparam logic [3:0] BOOT_HOST_P2M12 = 4'h4;
  localparam logic [3:0] BOOT_HOST_P1M12 = 4'h5;
  localparam logic [3:0] BOOT_RSV_6 = 4'h6;
  localparam logic [3:0] BOOT_HOST_P3M12 = 4'h7;
  localparam logic [3:0] BOOT_SPI_NOPLL = 4'h8;
  localparam logic [3:0] BOOT_SPI_P1M17 = 4'h9;
  localparam logic [3:0] BOOT_SPI_P2M16 = 4'hA;
  localparam logic [3:0] BOOT_SPI_P3M18 = 4'hB;
  localparam logic [3:0] BOOT_SPI_ALT = 4'hC;
  // clock select encodings
  localparam logic [1:0] CLK_SRC_DIRECT = 2'h0;
  localparam logic [1:0] CLK_SRC_PLL_A = 2'h1;
  localparam logic [1:0] CLK_SRC_PLL_B = 2'h3;
  // i2c bit clock divider
  localparam logic [7:0] I2C_BIT_DIV = 8'h80;
  // reset values
  localparam logic [3:0] RST_BOOT_MODE = 4'h0;
  localparam logic [1:0] RST_PREDIV = 2'h0;
  localparam logic [5:0] RST_MULT = 6'h00;
  // host boot group: four 16-bit words, msw first
  localparam int HOST_WORDS_PER_GROUP = 4;

  typedef enum logic [2:0] {
    RSB_PORT_HOST,
    RSB_PORT_I2C,
    RSB_PORT_SPI_MAIN,
    RSB_PORT_SPI_ALT,
    RSB_PORT_NONE
  } rsb_port_e;
endpackage

//--- src/rsb_dec_if.sv
`timescale 1ns/1ps
interface rsb_dec_if;
  logic [3:0] code;
  rsb_pkg::rsb_port_e port;
  logic pll_used;
  logic [1:0] prediv;
  logic [5:0] mult;
  logic [1:0] clk_src;
  logic range_bit;
  logic invalid;
  modport dec (input code, output port, pll_used, prediv, mult, clk_src, range_bit, invalid);
  modport top (output code, input port, pll_used, prediv, mult, clk_src, range_bit, invalid);
endinterface

//--- src/rsb_boot_decode.sv
`timescale 1ns/1ps
module rsb_boot_decode (
  rsb_dec_if.dec d
);
  always_comb begin
    d.port = rsb_pkg::RSB_PORT_NONE;
    d.pll_used = 1'b0;
    d.prediv = rsb_pkg::RST_PREDIV;
    d.mult = rsb_pkg::RST_MULT;
    d.clk_src = rsb_pkg::CLK_SRC_DIRECT;
    d.range_bit = 1'b0;
    d.invalid = 1'b0;
    case (d.code)
      rsb_pkg::BOOT_HOST_NOPLL: begin
        d.port = rsb_pkg::RSB_PORT_HOST;
      end
      rsb_pkg::BOOT_HOST_P1M12: begin
        d.port = rsb_pkg::RSB_PORT_HOST;
        d.pll_used = 1'b1;
        d.prediv = 2'h1;
        d.mult = 6'h0C;
        d.clk_src = rsb_pkg::CLK_SRC_PLL_B;
        d.range_bit = 1'b1;
      end
      rsb_pkg::BOOT_HOST_P2M32: begin
        d.port = rsb_pkg::RSB_PORT_HOST;
        d.pll_used = 1'b1;
        d.prediv = 2'h2;
        d.mult = 6'h20;
        d.clk_src = rsb_pkg::CLK_SRC_PLL_A;
        d.range_bit = 1'b1;
      end
      rsb_pkg::BOOT_HOST_P3M12: begin
        d.port = rsb_pkg::RSB_PORT_HOST;
        d.pll_used = 1'b1;
        d.prediv = 2'h3;
        d.mult = 6'h0C;
        d.clk_src = rsb_pkg::CLK_SRC_PLL_B;
        d.range_bit = 1'b1;
      end
      rsb_pkg::BOOT_HOST_P2M12: begin
        d.port = rsb_pkg::RSB_PORT_HOST;
        d.pll_used = 1'b1;
        d.prediv = 2'h2;
        d.mult = 6'h0C;
        d.clk_src = rsb_pkg::CLK_SRC_PLL_B;
        d.range_bit = 1'b1;
      end
      rsb_pkg::BOOT_SPI_NOPLL: begin
        d.port = rsb_pkg::RSB_PORT_SPI_MAIN;
      end
      rsb_pkg::BOOT_SPI_P1M17: begin
        d.port = rsb_pkg::RSB_PORT_SPI_MAIN;
        d.pll_used = 1'b1;
        d.prediv = 2'h1;
        d.mult = 6'h11;
        d.clk_src = rsb_pkg::CLK_SRC_PLL_B;
      end
      rsb_pkg::BOOT_SPI_P2M16: begin
        d.port = rsb_pkg::RSB_PORT_SPI_MAIN;
        d.pll_used = 1'b1;
        d.prediv = 2'h2;
        d.mult = 6'h10;
        d.clk_src = rsb_pkg::CLK_SRC_PLL_B;
      end
      rsb_pkg::BOOT_SPI_P3M18: begin
        d.port = rsb_pkg::RSB_PORT_SPI_MAIN;
        d.pll_used = 1'b1;
        d.prediv = 2'h3;
        d.mult = 6'h12;
        d.clk_src = rsb_pkg::CLK_SRC_PLL_B;
      end
      rsb_pkg::BOOT_SPI_ALT: begin
        d.port = rsb_pkg::RSB_PORT_SPI_ALT;
      end
      rsb_pkg::BOOT_I2C: begin
        d.port = rsb_pkg::RSB_PORT_I2C;
      end
      default: begin
        d.invalid = 1'b1;
      end
    endcase
  end
endmodule // rsb_boot_decode

//--- src/rsb_reset_strap.sv
`timescale 1ns/1ps
// Contract
// - Boot, watchdog, strobe polarity and width straps are latched as power-on reset ends.
// - Latched watchdog strap 0 disables the watchdog and 1 enables it.
// - Latched strobe polarity strap 0 gives active-low host strobes and 1 active-high.
// - Latched width strap 0 gives a 16-bit host port and 1 gives an 8-bit port.
// - After power-on reset the PLL is bypassed until boot software enables it.
// - Code 0000 is host boot without PLL, clock select 00, range 0.
// - Host PLL codes 0101, 0010, 0111, 0100 give their predivide, multiply, select, range 1.
// - Codes 1000 to 1011 are main-pin SPI boot with range 0, 1000 without PLL and 1001 to 1011 with their PLL settings.
// - Code 1100 is alternate-pin SPI boot without PLL and clock select 00.
// - Host boot runs the port without DMA and polled on both sides.
// - Host strobe configuration follows the polarity strap and the dual-strobe select pin.
// - Host port straps are captured only at power-on reset end, not at hard reset.
// - Host data port bit 0 is always the least significant bit.
module rsb_reset_strap (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic power_on_reset_in_i,
  input wire logic hard_reset_i,
  input wire logic [3:0] boot_mode_straps_i,
  input wire logic watchdog_enable_strap_i,
  input wire logic host_strobe_polarity_strap_i,
  input wire logic host_narrow_width_strap_i,
  input wire logic host_dual_strobe_select_i,
  input wire logic pll_enable_req_i,
  output logic [3:0] boot_mode_o,
  output rsb_pkg::rsb_port_e boot_port_o,
  output logic boot_mode_invalid_o,
  output logic pll_bypass_o,
  output logic pll_config_valid_o,
  output logic [1:0] pll_prediv_o,
  output logic [5:0] pll_mult_o,
  output logic [1:0] clock_source_select_o,
  output logic pll_range_bit_o,
  output logic [7:0] i2c_bit_div_o,
  output logic watchdog_enable_o,
  output logic host_strobe_active_high_o,
  output logic host_dual_strobe_o,
  output logic host_narrow_width_o,
  output logic host_dma_enable_o,
  output logic host_polled_mode_o,
  output logic host_data_lsb0_o,
  output logic config_ready_o
);
  // power_on_reset_in_i is active low: high releases it
  rsb_dec_if dif ();
  logic por_prev;
  logic [3:0] boot_mode;
  rsb_pkg::rsb_port_e boot_port;
  logic invalid, bypass, cfg_valid, range_bit, wdog, pol, dual, narrow, dma, polled, ready;
  logic [1:0] prediv, clk_src;
  logic [5:0] mult;
  logic [7:0] i2c_div;
  logic next_por_prev;
  logic [3:0] next_boot_mode;
  rsb_pkg::rsb_port_e next_boot_port;
  logic next_invalid, next_bypass, next_cfg_valid, next_range_bit, next_wdog, next_pol;
  logic next_dual, next_narrow, next_dma, next_polled, next_ready;
  logic [1:0] next_prediv, next_clk_src;
  logic [5:0] next_mult;
  logic [7:0] next_i2c_div;
  logic por_rise;

  assign dif.code = boot_mode_straps_i;
  rsb_boot_decode u_dec (
    .d(dif.dec)
  );

  always_comb begin
    por_rise = power_on_reset_in_i & ~por_prev;
    next_por_prev = power_on_reset_in_i;
    next_boot_mode = boot_mode;
    next_boot_port = boot_port;
    next_invalid = invalid;
    next_bypass = bypass;
    next_cfg_valid = cfg_valid;
    next_prediv = prediv;
    next_mult = mult;
    next_clk_src = clk_src;
    next_range_bit = range_bit;
    next_i2c_div = i2c_div;
    next_wdog = wdog;
    next_pol = pol;
    next_dual = dual;
    next_narrow = narrow;
    next_dma = dma;
    next_polled = polled;
    next_ready = ready;
    if (!power_on_reset_in_i) begin
      // held in reset: bypass PLL, clear readiness
      next_bypass = 1'b1;
      next_ready = 1'b0;
    end else if (por_rise) begin
      next_boot_mode = boot_mode_straps_i;
      next_boot_port = dif.port;
      next_invalid = dif.invalid;
      next_cfg_valid = dif.pll_used & ~dif.invalid;
      next_prediv = dif.prediv;
      next_mult = dif.mult;
      next_clk_src = dif.clk_src;
      next_range_bit = dif.range_bit;
      next_i2c_div = (dif.port == rsb_pkg::RSB_PORT_I2C) ? rsb_pkg::I2C_BIT_DIV : 8'h00;
      next_wdog = watchdog_enable_strap_i;
      // host straps only here, so a hard reset cannot touch them
      next_pol = host_strobe_polarity_strap_i;
      next_dual = host_dual_strobe_select_i;
      next_narrow = host_narrow_width_strap_i;
      next_dma = 1'b0;
      next_polled = (dif.port == rsb_pkg::RSB_PORT_HOST);
      next_bypass = 1'b1;
      next_ready = 1'b1;
    end else if (hard_reset_i) begin
      // hard reset reruns boot with PLL bypassed; host config kept
      next_bypass = 1'b1;
    end else if (pll_enable_req_i && ready && cfg_valid) begin
      next_bypass = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      por_prev <= 1'b0;
      boot_mode <= rsb_pkg::RST_BOOT_MODE;
      boot_port <= rsb_pkg::RSB_PORT_NONE;
      invalid <= 1'b0;
      bypass <= 1'b1;
      cfg_valid <= 1'b0;
      prediv <= rsb_pkg::RST_PREDIV;
      mult <= rsb_pkg::RST_MULT;
      clk_src <= rsb_pkg::CLK_SRC_DIRECT;
      range_bit <= 1'b0;
      i2c_div <= 8'h00;
      wdog <= 1'b0;
      pol <= 1'b0;
      dual <= 1'b0;
      narrow <= 1'b0;
      dma <= 1'b0;
      polled <= 1'b0;
      ready <= 1'b0;
    end else begin
      por_prev <= next_por_prev;
      boot_mode <= next_boot_mode;
      boot_port <= next_boot_port;
      invalid <= next_invalid;
      bypass <= next_bypass;
      cfg_valid <= next_cfg_valid;
      prediv <= next_prediv;
      mult <= next_mult;
      clk_src <= next_clk_src;
      range_bit <= next_range_bit;
      i2c_div <= next_i2c_div;
      wdog <= next_wdog;
      pol <= next_pol;
      dual <= next_dual;
      narrow <= next_narrow;
      dma <= next_dma;
      polled <= next_polled;
      ready <= next_ready;
    end
  end

  assign boot_mode_o = boot_mode;
  assign boot_port_o = boot_port;
  assign boot_mode_invalid_o = invalid;
  assign pll_bypass_o = bypass;
  assign pll_config_valid_o = cfg_valid;
  assign pll_prediv_o = prediv;
  assign pll_mult_o = mult;
  assign clock_source_select_o = clk_src;
  assign pll_range_bit_o = range_bit;
  assign i2c_bit_div_o = i2c_div;
  assign watchdog_enable_o = wdog;
  assign host_strobe_active_high_o = pol;
  assign host_dual_strobe_o = dual;
  assign host_narrow_width_o = narrow;
  assign host_dma_enable_o = dma;
  assign host_polled_mode_o = polled;
  assign host_data_lsb0_o = 1'b1; // fixed bit order, no swap option
  assign config_ready_o = ready;

  // assertions
  property p_latch_boot;
    @(posedge clock_i) disable iff (srst_i)
      por_rise |=> (boot_mode_o == $past(boot_mode_straps_i));
  endproperty
  a_latch_boot: assert property (p_latch_boot) else $error("boot mode not latched");

  property p_hold;
    @(posedge clock_i) disable iff (srst_i)
      (power_on_reset_in_i && por_prev) |=> $stable(boot_mode_o) && $stable(watchdog_enable_o);
  endproperty
  a_hold: assert property (p_hold) else $error("latched straps changed");

  property p_wdog;
    @(posedge clock_i) disable iff (srst_i)
      por_rise |=> (watchdog_enable_o == $past(watchdog_enable_strap_i));
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog strap wrong");

  property p_pol;
    @(posedge clock_i) disable iff (srst_i)
      por_rise |=> (host_strobe_active_high_o == $past(host_strobe_polarity_strap_i))
        && (host_dual_strobe_o == $past(host_dual_strobe_select_i));
  endproperty
  a_pol: assert property (p_pol) else $error("strobe config wrong");

  property p_width;
    @(posedge clock_i) disable iff (srst_i)
      por_rise |=> (host_narrow_width_o == $past(host_narrow_width_strap_i));
  endproperty
  a_width: assert property (p_width) else $error("width strap wrong");

  property p_bypass;
    @(posedge clock_i) disable iff (srst_i)
      por_rise |=> pll_bypass_o;
  endproperty
  a_bypass: assert property (p_bypass) else $error("pll not bypassed after reset");

  property p_code0;
    @(posedge clock_i) disable iff (srst_i)
      (por_rise && boot_mode_straps_i == 4'h0) |=>
        (clock_source_select_o == 2'h0) && !pll_range_bit_o && !pll_config_valid_o;
  endproperty
  a_code0: assert property (p_code0) else $error("code 0000 decode wrong");

  property p_code2;
    @(posedge clock_i) disable iff (srst_i)
      (por_rise && boot_mode_straps_i == 4'h2) |=> (pll_mult_o == 6'h20)
        && (pll_prediv_o == 2'h2) && (clock_source_select_o == 2'h1) && pll_range_bit_o;
  endproperty
  a_code2: assert property (p_code2) else $error("code 0010 decode wrong");

  property p_spi;
    @(posedge clock_i) disable iff (srst_i)
      (por_rise && boot_mode_straps_i == 4'h9) |=> (pll_mult_o == 6'h11)
        && (clock_source_select_o == 2'h3) && !pll_range_bit_o;
  endproperty
  a_spi: assert property (p_spi) else $error("code 1001 decode wrong");

  property p_i2c;
    @(posedge clock_i) disable iff (srst_i)
      (por_rise && boot_mode_straps_i == 4'h1) |=> (i2c_bit_div_o == 8'h80);
  endproperty
  a_i2c: assert property (p_i2c) else $error("i2c divider wrong");

  property p_hard;
    @(posedge clock_i) disable iff (srst_i)
      (power_on_reset_in_i && por_prev && hard_reset_i) |=> $stable(host_narrow_width_o)
        && $stable(host_strobe_active_high_o) && pll_bypass_o;
  endproperty
  a_hard: assert property (p_hard) else $error("hard reset changed host config");

  property p_rsv;
    @(posedge clock_i) disable iff (srst_i)
      boot_mode_invalid_o |-> !pll_config_valid_o ##1 pll_bypass_o;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved code configured pll");

  property p_rsv_port;
    @(posedge clock_i) disable iff (srst_i)
      (por_rise && boot_mode_straps_i == 4'hF) |=> boot_mode_invalid_o
        && (boot_port_o == rsb_pkg::RSB_PORT_NONE) && (pll_mult_o == 6'h00);
  endproperty
  a_rsv_port: assert property (p_rsv_port) else $error("reserved code not flagged");

  property p_code5;
    @(posedge clock_i) disable iff (srst_i)
      (por_rise && boot_mode_straps_i == 4'h5) |=> (pll_prediv_o == 2'h1) && (pll_mult_o == 6'h0C)
        && (clock_source_select_o == 2'h3) && pll_range_bit_o && pll_config_valid_o;
  endproperty
  a_code5: assert property (p_code5) else $error("code 0101 decode wrong");

  property p_spi_b;
    @(posedge clock_i) disable iff (srst_i)
      (por_rise && boot_mode_straps_i == 4'hB) |=> (pll_prediv_o == 2'h3) && (pll_mult_o == 6'h12)
        && (clock_source_select_o == 2'h3) && !pll_range_bit_o;
  endproperty
  a_spi_b: assert property (p_spi_b) else $error("code 1011 decode wrong");

  property p_spi_alt;
    @(posedge clock_i) disable iff (srst_i)
      (por_rise && boot_mode_straps_i == 4'hC) |=> (boot_port_o == rsb_pkg::RSB_PORT_SPI_ALT)
        && (clock_source_select_o == 2'h0) && !pll_config_valid_o;
  endproperty
  a_spi_alt: assert property (p_spi_alt) else $error("code 1100 decode wrong");

  property p_i2c_port;
    @(posedge clock_i) disable iff (srst_i)
      (por_rise && boot_mode_straps_i == 4'h1) |=> (boot_port_o == rsb_pkg::RSB_PORT_I2C)
        && (clock_source_select_o == 2'h0) && !pll_config_valid_o;
  endproperty
  a_i2c_port: assert property (p_i2c_port) else $error("code 0001 decode wrong");

  property p_host_poll;
    @(posedge clock_i) disable iff (srst_i)
      por_rise |=> !host_dma_enable_o
        && (host_polled_mode_o == (boot_port_o == rsb_pkg::RSB_PORT_HOST));
  endproperty
  a_host_poll: assert property (p_host_poll) else $error("host port mode wrong");

  property p_por_low;
    @(posedge clock_i) disable iff (srst_i)
      !power_on_reset_in_i |=> pll_bypass_o && !config_ready_o;
  endproperty
  a_por_low: assert property (p_por_low) else $error("bypass lost in reset");

  // leaving bypass needs both a finished latch and a pll code
  property p_refuse;
    @(posedge clock_i) disable iff (srst_i)
      (pll_bypass_o && !(config_ready_o && pll_config_valid_o)) |=> pll_bypass_o;
  endproperty
  a_refuse: assert property (p_refuse) else $error("pll enabled without config");

  c_host: cover property (@(posedge clock_i) por_rise && boot_mode_straps_i == 4'h5);
  c_spi_alt: cover property (@(posedge clock_i) por_rise && boot_mode_straps_i == 4'hC);
  c_hard: cover property (@(posedge clock_i) hard_reset_i && config_ready_o && !pll_bypass_o);
  c_pll_on: cover property (@(posedge clock_i) $fell(pll_bypass_o));
  c_rsv: cover property (@(posedge clock_i) $rose(boot_mode_invalid_o));
endmodule // rsb_reset_strap

//--- tb/rsb_strap_board.sv
`timescale 1ns/1ps
// board strap wiring: straps driven while the reset pin is held low
// no host data port here: a host partner polls and sends four-word groups msw first
module rsb_strap_board (
  input wire logic clock_i,
  input wire logic por_req_i,
  input wire logic [7:0] strap_val_i,
  output logic power_on_reset_in_o,
  output logic [7:0] straps_o
);
  logic [1:0] held;
  initial begin
    power_on_reset_in_o = 1'b0;
    straps_o = 8'h00;
    held = 2'h0;
  end
  always @(posedge clock_i) begin
    if (por_req_i) begin
      power_on_reset_in_o <= 1'b0;
      straps_o <= strap_val_i;
      held <= 2'h0;
    end else begin
      power_on_reset_in_o <= 1'b1;
      // straps float once the hold has run out: toggle so a late sample shows
      if (held != 2'h3) begin
        held <= held + 2'h1;
      end else begin
        straps_o <= ~straps_o;
      end
    end
  end
endmodule // rsb_strap_board

//--- tb/rsb_reset_strap_tb.sv
`timescale 1ns/1ps
module rsb_reset_strap_tb;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic hard_reset_i = 1'b0;
  logic pll_enable_req_i = 1'b0;
  logic por_req = 1'b1;
  logic [7:0] strap_val = 8'h00;
  logic [7:0] straps;
  logic por_in;
  logic [3:0] boot_mode_o;
  rsb_pkg::rsb_port_e boot_port_o;
  logic boot_mode_invalid_o, pll_bypass_o, pll_config_valid_o, pll_range_bit_o;
  logic [1:0] pll_prediv_o, clock_source_select_o;
  logic [5:0] pll_mult_o;
  logic [7:0] i2c_bit_div_o;
  logic watchdog_enable_o, host_strobe_active_high_o, host_dual_strobe_o;
  logic host_narrow_width_o, host_dma_enable_o, host_polled_mode_o;
  logic host_data_lsb0_o, config_ready_o;
  logic [15:0] cfg, flags;
  int bad_count = 0;
  int comparisons = 0;

  // 50 MHz input clock keeps the i2c bit rate in range
  always #10 clock_i = ~clock_i;

  assign cfg = {boot_port_o, pll_config_valid_o, pll_prediv_o, pll_mult_o,
    clock_source_select_o, pll_range_bit_o, boot_mode_invalid_o};
  assign flags = {boot_mode_o, watchdog_enable_o, host_strobe_active_high_o,
    host_dual_strobe_o, host_narrow_width_o, host_dma_enable_o, host_polled_mode_o,
    host_data_lsb0_o, pll_bypass_o, config_ready_o, 3'h0};

  rsb_strap_board u_board (
    .clock_i(clock_i),
    .por_req_i(por_req),
    .strap_val_i(strap_val),
    .power_on_reset_in_o(por_in),
    .straps_o(straps)
  );

  rsb_reset_strap u_dut (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .power_on_reset_in_i(por_in),
    .hard_reset_i(hard_reset_i),
    .boot_mode_straps_i(straps[3:0]),
    .watchdog_enable_strap_i(straps[4]),
    .host_strobe_polarity_strap_i(straps[5]),
    .host_narrow_width_strap_i(straps[6]),
    .host_dual_strobe_select_i(straps[7]),
    .pll_enable_req_i(pll_enable_req_i),
    .boot_mode_o(boot_mode_o),
    .boot_port_o(boot_port_o),
    .boot_mode_invalid_o(boot_mode_invalid_o),
    .pll_bypass_o(pll_bypass_o),
    .pll_config_valid_o(pll_config_valid_o),
    .pll_prediv_o(pll_prediv_o),
    .pll_mult_o(pll_mult_o),
    .clock_source_select_o(clock_source_select_o),
    .pll_range_bit_o(pll_range_bit_o),
    .i2c_bit_div_o(i2c_bit_div_o),
    .watchdog_enable_o(watchdog_enable_o),
    .host_strobe_active_high_o(host_strobe_active_high_o),
    .host_dual_strobe_o(host_dual_strobe_o),
    .host_narrow_width_o(host_narrow_width_o),
    .host_dma_enable_o(host_dma_enable_o),
    .host_polled_mode_o(host_polled_mode_o),
    .host_data_lsb0_o(host_data_lsb0_o),
    .config_ready_o(config_ready_o)
  );

  // {port, pll used, prediv, mult, clock select, range, invalid}
  function automatic logic [15:0] exp_cfg(input logic [3:0] c);
    case (c)
      4'h0: exp_cfg = {rsb_pkg::RSB_PORT_HOST, 13'h0000};
      4'h1: exp_cfg = {rsb_pkg::RSB_PORT_I2C, 13'h0000};
      4'h2: exp_cfg = {rsb_pkg::RSB_PORT_HOST, 1'b1, 2'h2, 6'h20, 2'h1, 2'h2};
      4'h4: exp_cfg = {rsb_pkg::RSB_PORT_HOST, 1'b1, 2'h2, 6'h0C, 2'h3, 2'h2};
      4'h5: exp_cfg = {rsb_pkg::RSB_PORT_HOST, 1'b1, 2'h1, 6'h0C, 2'h3, 2'h2};
      4'h7: exp_cfg = {rsb_pkg::RSB_PORT_HOST, 1'b1, 2'h3, 6'h0C, 2'h3, 2'h2};
      4'h8: exp_cfg = {rsb_pkg::RSB_PORT_SPI_MAIN, 13'h0000};
      4'h9: exp_cfg = {rsb_pkg::RSB_PORT_SPI_MAIN, 1'b1, 2'h1, 6'h11, 2'h3, 2'h0};
      4'hA: exp_cfg = {rsb_pkg::RSB_PORT_SPI_MAIN, 1'b1, 2'h2, 6'h10, 2'h3, 2'h0};
      4'hB: exp_cfg = {rsb_pkg::RSB_PORT_SPI_MAIN, 1'b1, 2'h3, 6'h12, 2'h3, 2'h0};
      4'hC: exp_cfg = {rsb_pkg::RSB_PORT_SPI_ALT, 13'h0000};
      default: exp_cfg = {rsb_pkg::RSB_PORT_NONE, 12'h000, 1'b1};
    endcase
  endfunction

  task automatic print_verdict();
    if (bad_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clock_i);
    #2;
  endtask

  task automatic boot(input logic [3:0] c);
    logic [15:0] e;
    logic [15:0] f;
    int i;
    e = exp_cfg(c);
    f = {c, c[0], c[1], c[3], c[2], 1'b0, e[15:13] == rsb_pkg::RSB_PORT_HOST, 3'h7, 3'h0};
    strap_val = {c, c};
    // software request while the reset pin is low must not leave bypass
    pll_enable_req_i = 1'b1;
    por_req = 1'b1;
    cycles(3);
    check({14'h0, config_ready_o, pll_bypass_o}, 16'h0001);
    pll_enable_req_i = 1'b0;
    por_req = 1'b0;
    i = 0;
    while (config_ready_o !== 1'b1 && i < 8) begin
      cycles(1);
      i++;
    end
    if (config_ready_o !== 1'b1) begin
      bad_count++;
      print_verdict();
    end
    // by now the board straps toggle every cycle
    cycles(3);
    check(cfg, e);
    check({8'h00, i2c_bit_div_o}, (c == 4'h1) ? 16'h0080 : 16'h0000);
    check(flags, f);
    pll_enable_req_i = 1'b1;
    cycles(2);
    check({15'h0, pll_bypass_o}, {15'h0, ~e[12]});
    hard_reset_i = 1'b1;
    pll_enable_req_i = 1'b0;
    cycles(1);
    hard_reset_i = 1'b0;
    cycles(2);
    check(flags, f);
  endtask

  initial begin
    cycles(5);
    srst_i = 1'b0;
    for (int k = 0; k < 16; k++) begin
      boot(4'(k));
    end
    srst_i = 1'b1;
    cycles(2);
    check(cfg, {rsb_pkg::RSB_PORT_NONE, 13'h0000});
    check(flags, 16'h0030);
    srst_i = 1'b0;
    boot(4'h5);
    print_verdict();
  end
endmodule // rsb_reset_strap_tb
